/* File: pkg/sew_pkg.sv */
package sew_pkg;

	// Array shape
	localparam int WORD_W = 8;
	localparam int ADDR_W = 12;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_COUNT = 128;
	localparam int OFS_W = 5;
	localparam int ROW_W = ADDR_W - OFS_W;

	// Fixed device type code of the address byte
	localparam logic [3:0] DEV_TYPE = 4'ha;

	// Falling-edge counts inside one nine-clock word
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] CNT_RST = 4'h0;

	// Values after reset
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
	localparam logic [PAGE_BYTES-1:0] MASK_RST = 32'h0000_0000;
	localparam logic [WORD_W-1:0] BYTE_RST = 8'h00;

	// Self-timed programming: longest time, rounded down to whole cycles
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int PROG_CNT_W = 20;

	// Link side protocol states
	typedef enum logic [2:0] {
		LK_IDLE,
		LK_DEVADDR,
		LK_ADDR_HI,
		LK_ADDR_LO,
		LK_WDATA,
		LK_RDATA
	} sew_link_t;

	// Programming engine states
	typedef enum logic {
		PR_IDLE,
		PR_RUN
	} sew_prog_t;

endpackage

/* File: hw/sew_mem.sv */
// Simple dual-clock memory, registered read data
module sew_mem #(
	parameter int DATA_W = 8,
	parameter int DEPTH_W = 12
) (
	input wire logic wr_clk_in,
	input wire logic we_in,
	input wire logic [DEPTH_W-1:0] waddr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic rd_clk_in,
	input wire logic [DEPTH_W-1:0] raddr_in,
	output logic [DATA_W-1:0] rdata_out
);

	logic [DATA_W-1:0] mem_r [0:(1<<DEPTH_W)-1];

	// Write port; no reset, contents survive like the real array
	always_ff @(posedge wr_clk_in) begin
		if (we_in) begin
			mem_r[waddr_in] <= wdata_in;
		end
	end

	// Read port, one edge of latency
	always_ff @(posedge rd_clk_in) begin
		rdata_out <= mem_r[raddr_in];
	end

endmodule

/* File: hw/sew_port.sv */
// Behaviour
// - Sample data on serial clock rise, change output after its fall.
// - Unconnected chip-select straps count as low in the address compare.
// - Data line is only pulled low or released, never driven high.
// - Protect input high blocks all programming; reads are unaffected.
// - Unconnected protect input counts as low, programming enabled.
// - Array is 128 pages of 32 bytes, reached by a 12-bit address.
// - Data falling while clock high is a start; commands begin with it.
// - Data rising while clock high is a stop; after a read, standby.
// - Stop after a write launches self-timed programming, standby afterwards.
// - Each received eight-bit word is acknowledged low on the ninth clock.
// - Address byte: top four bits 1010, next three match straps, last direction.
// - Mismatch gets no acknowledge and standby; match acknowledged after direction.
// - Direction one selects read mode, zero selects programming mode.
// - Byte write: two address bytes then one data byte, each acknowledged.
// - During the write cycle all bus traffic is ignored.
// - Programming cycle, erase included, finishes within five milliseconds.
// - Page write carries up to 32 data bytes, every one acknowledged.
// - Only the low five address bits advance after each data byte.
// - Past 32 bytes the page offset wraps and overwrites earlier bytes.
// - Address byte not acknowledged while programming, normally afterwards.
// - Start, eighteen ones, start returns the protocol to idle.
// - One shared address counter holds last address plus one.
// - Start after address bytes but before data abandons the pending write.
module sew_port import sew_pkg::*; #(
	parameter int PROG_LEN = PROG_CYCLES
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [2:0] chip_select_straps_in,
	input wire logic wp_in,
	output logic busy_out
);

	localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_LEN - 1);
	localparam logic [PROG_CNT_W-1:0] COPY_END = PROG_CNT_W'(PAGE_BYTES);
	localparam logic [PROG_CNT_W-1:0] PCNT_RST = PROG_CNT_W'(0);

	// Page offset step, wraps inside the page
	function automatic logic [OFS_W-1:0] sew_inc_ofs(input logic [OFS_W-1:0] ofs);
		sew_inc_ofs = ofs + 1'b1;
	endfunction

	// Start and stop flags, clocked by the data line itself
	logic start_tog_r;
	logic stop_tog_r;

	// Link domain, falling edge of the serial clock
	sew_link_t state_r;
	sew_link_t state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic start_seen_r;
	logic sda_oe_r;
	logic sda_oe_nxt;
	logic dev_ack_r;
	logic data_r;
	logic [ADDR_W-1:0] addr_r;
	logic [3:0] hi_r;
	logic [PAGE_BYTES-1:0] mask_r;
	logic [WORD_W-1:0] tx_r;
	logic busy_m_r;
	logic busy_s_r;
	logic [2:0] strap_m_r;
	logic [2:0] strap_s_r;

	// Link domain, rising edge of the serial clock
	logic [WORD_W-1:0] rx_r;
	logic mack_r;

	// System clock domain
	logic stop_m_r;
	logic stop_s_r;
	logic stop_d_r;
	logic wp_m_r;
	logic wp_s_r;
	sew_prog_t pstate_r;
	logic [PROG_CNT_W-1:0] pcnt_r;
	logic [OFS_W-1:0] cp_idx_r;
	logic cp_vld_r;
	logic busy_r;
	logic [PAGE_BYTES-1:0] snap_r;

	logic [WORD_W-1:0] arr_rdata;
	logic [WORD_W-1:0] buf_rdata;

	// Start: data falls while clock is high
	always_ff @(negedge sda_in or negedge rstn_in) begin
		if (!rstn_in) begin
			start_tog_r <= 1'b0;
		end else if (scl_in) begin
			start_tog_r <= ~start_tog_r;
		end
	end

	// Stop: data rises while clock is high
	always_ff @(posedge sda_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stop_tog_r <= 1'b0;
		end else if (scl_in) begin
			stop_tog_r <= ~stop_tog_r;
		end
	end

	// Word decode; start toggle is source-synchronous to the next clock fall
	wire start_ev = start_tog_r ^ start_seen_r;
	wire word_done = (cnt_r == BIT_LAST) && !start_ev;
	wire ack_slot = (cnt_r == BIT_ACK) && !start_ev;
	wire type_ok = (rx_r[7:4] == DEV_TYPE);
	wire strap_ok = (rx_r[3:1] == strap_s_r);
	wire dev_match = type_ok && strap_ok && !busy_s_r;
	wire rd_dir = rx_r[0];
	wire in_read = (state_r == LK_RDATA);
	wire rd_load = ack_slot && in_read && (dev_ack_r || !mack_r);
	wire ack_byte = (state_r == LK_ADDR_HI) || (state_r == LK_ADDR_LO) || (state_r == LK_WDATA);
	wire ack_now = ((state_r == LK_DEVADDR) && dev_match) || ack_byte;
	wire [OFS_W-1:0] ofs_nxt = sew_inc_ofs(addr_r[OFS_W-1:0]);

	// Next protocol state
	always_comb begin
		state_nxt = state_r;
		if (start_ev) begin
			state_nxt = LK_DEVADDR;
		end else if (word_done) begin
			unique case (state_r)
				LK_IDLE: state_nxt = LK_IDLE;
				LK_DEVADDR: begin
					if (!dev_match) begin
						state_nxt = LK_IDLE;
					end else if (rd_dir) begin
						state_nxt = LK_RDATA;
					end else begin
						state_nxt = LK_ADDR_HI;
					end
				end
				LK_ADDR_HI: state_nxt = LK_ADDR_LO;
				LK_ADDR_LO: state_nxt = LK_WDATA;
				LK_WDATA: state_nxt = LK_WDATA;
				LK_RDATA: state_nxt = LK_RDATA;
			endcase
		end else if (ack_slot && in_read && !dev_ack_r && mack_r) begin
			state_nxt = LK_IDLE; // Controller declined another byte
		end
	end

	// Bit counter; idle holds it so stray clocks do nothing
	always_comb begin
		if (start_ev || (state_r == LK_IDLE) || (cnt_r == BIT_ACK)) begin
			cnt_nxt = CNT_RST;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	// Pull-down enable; data only changes after a clock fall
	always_comb begin
		if (start_ev) begin
			sda_oe_nxt = 1'b0;
		end else if (word_done) begin
			sda_oe_nxt = ack_now;
		end else if (rd_load) begin
			sda_oe_nxt = ~arr_rdata[7];
		end else if (ack_slot) begin
			sda_oe_nxt = 1'b0;
		end else if (in_read && (cnt_r != BIT_ACK)) begin
			sda_oe_nxt = ~tx_r[7];
		end else begin
			sda_oe_nxt = 1'b0;
		end
	end

	// Protocol registers on the clock fall
	always_ff @(negedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= LK_IDLE;
			cnt_r <= CNT_RST;
			start_seen_r <= 1'b0;
			sda_oe_r <= 1'b0;
			dev_ack_r <= 1'b0;
			data_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			start_seen_r <= start_tog_r;
			sda_oe_r <= sda_oe_nxt;
			dev_ack_r <= word_done ? ack_now : dev_ack_r;
			data_r <= word_done ? (state_r == LK_WDATA) : (data_r && !ack_slot);
		end
	end

	// Shared address counter
	always_ff @(negedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_r <= ADDR_RST;
			hi_r <= 4'h0;
		end else if (word_done && (state_r == LK_ADDR_HI)) begin
			hi_r <= rx_r[3:0]; // Top nibble is don't care
		end else if (word_done && (state_r == LK_ADDR_LO)) begin
			addr_r <= {hi_r, rx_r};
		end else if (ack_slot && data_r) begin
			addr_r[OFS_W-1:0] <= ofs_nxt; // Row untouched, offset wraps
		end else if (rd_load) begin
			addr_r <= addr_r + 1'b1; // Reads roll over the whole array
		end
	end

	// Loaded-byte mask; every start clears it, the engine works from its own copy
	always_ff @(negedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_r <= MASK_RST;
		end else if (start_ev) begin
			mask_r <= MASK_RST;
		end else if (word_done && (state_r == LK_WDATA)) begin
			mask_r[addr_r[OFS_W-1:0]] <= 1'b1;
		end
	end

	// Outgoing byte shifter, most significant bit first
	always_ff @(negedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_r <= BYTE_RST;
		end else if (rd_load) begin
			tx_r <= {arr_rdata[6:0], 1'b1};
		end else if (in_read && !ack_slot) begin
			tx_r <= {tx_r[6:0], 1'b1};
		end
	end

	// Level crossings into the link domain; second stage is the only reader
	always_ff @(negedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			busy_m_r <= 1'b0;
			busy_s_r <= 1'b0;
			strap_m_r <= 3'h0;
			strap_s_r <= 3'h0;
		end else begin
			busy_m_r <= busy_r;
			busy_s_r <= busy_m_r;
			strap_m_r <= chip_select_straps_in; // Pad pull-down reads open as low
			strap_s_r <= strap_m_r;
		end
	end

	// Receive on the clock rise
	always_ff @(posedge scl_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_r <= BYTE_RST;
			mack_r <= 1'b1;
		end else if (cnt_r == BIT_ACK) begin
			mack_r <= sda_in;
		end else begin
			rx_r <= {rx_r[6:0], sda_in};
		end
	end

	// Open drain: the driven level is always low
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_oe_r;

	// Page buffer, filled at the ninth rise, drained by the engine
	sew_mem #(
		.DATA_W(WORD_W),
		.DEPTH_W(OFS_W)
	) u_page (
		.wr_clk_in(scl_in),
		.we_in((cnt_r == BIT_ACK) && data_r),
		.waddr_in(addr_r[OFS_W-1:0]),
		.wdata_in(rx_r),
		.rd_clk_in(clk_in),
		.raddr_in(pcnt_r[OFS_W-1:0]),
		.rdata_out(buf_rdata)
	);

	// Main array: programmed on the system clock, read on the serial clock
	wire arr_we = cp_vld_r && snap_r[cp_idx_r];
	wire [ADDR_W-1:0] arr_waddr = {addr_r[ADDR_W-1:OFS_W], cp_idx_r};

	sew_mem #(
		.DATA_W(WORD_W),
		.DEPTH_W(ADDR_W)
	) u_array (
		.wr_clk_in(clk_in),
		.we_in(arr_we),
		.waddr_in(arr_waddr),
		.wdata_in(buf_rdata),
		.rd_clk_in(scl_in),
		.raddr_in(addr_r),
		.rdata_out(arr_rdata)
	);

	// Stop toggle and protect pin into the system domain
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stop_m_r <= 1'b0;
			stop_s_r <= 1'b0;
			stop_d_r <= 1'b0;
			wp_m_r <= 1'b0;
			wp_s_r <= 1'b0;
		end else begin
			stop_m_r <= stop_tog_r;
			stop_s_r <= stop_m_r;
			stop_d_r <= stop_s_r;
			wp_m_r <= wp_in; // Pad pull-down reads open as low
			wp_s_r <= wp_m_r;
		end
	end

	// Row is quiet once the stop is seen; the mask is copied at launch, since a poll start clears it
	wire stop_ev = stop_s_r ^ stop_d_r;
	wire wr_pend = |mask_r;
	wire prog_go = (pstate_r == PR_IDLE) && stop_ev && wr_pend && !wp_s_r;
	wire prog_end = (pstate_r == PR_RUN) && (pcnt_r == PROG_LAST);

	// Programming engine; a read's stop leaves it idle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pstate_r <= PR_IDLE;
			pcnt_r <= PCNT_RST;
			busy_r <= 1'b0;
			snap_r <= MASK_RST;
		end else if (prog_go) begin
			pstate_r <= PR_RUN;
			pcnt_r <= PCNT_RST;
			busy_r <= 1'b1;
			snap_r <= mask_r;
		end else if (prog_end) begin
			pstate_r <= PR_IDLE; // Standby once the cycle is over
			busy_r <= 1'b0;
		end else if (pstate_r == PR_RUN) begin
			pcnt_r <= pcnt_r + 1'b1;
		end
	end

	// Copy pipeline, one byte per cycle; erase folds into the overwrite
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cp_idx_r <= 5'h00;
			cp_vld_r <= 1'b0;
		end else begin
			cp_idx_r <= pcnt_r[OFS_W-1:0];
			cp_vld_r <= (pstate_r == PR_RUN) && (pcnt_r < COPY_END);
		end
	end

	assign busy_out = busy_r;

	// Link-domain checks
	sequence s_word_done(logic [2:0] st);
		(cnt_r == BIT_LAST) && !start_ev && (state_r == st);
	endsequence

	sequence s_released;
		!sda_oe_r && (state_r == LK_IDLE);
	endsequence

	a_ack_addr_byte: assert property (@(negedge scl_in) disable iff (!rstn_in)
		s_word_done(LK_ADDR_HI) |=> sda_oe_r ##1 (!sda_oe_r || start_ev))
		else $error("address byte not acknowledged for one clock");

	a_nack_busy: assert property (@(negedge scl_in) disable iff (!rstn_in)
		(s_word_done(LK_DEVADDR) and (busy_s_r == 1'b1)) |=> s_released)
		else $error("address acknowledged during programming");

	a_nack_mismatch: assert property (@(negedge scl_in) disable iff (!rstn_in)
		(s_word_done(LK_DEVADDR) and (rx_r[7:4] != DEV_TYPE)) |=> s_released)
		else $error("wrong device type was acknowledged");

	a_read_dir: assert property (@(negedge scl_in) disable iff (!rstn_in)
		(s_word_done(LK_DEVADDR) and dev_match && rd_dir) |=> sda_oe_r && in_read)
		else $error("read direction did not enter read mode");

	a_start_restart: assert property (@(negedge scl_in) disable iff (!rstn_in)
		start_ev |=> (state_r == LK_DEVADDR) && (cnt_r == CNT_RST) && !sda_oe_r)
		else $error("start did not restart the protocol");

	a_offset_wrap: assert property (@(negedge scl_in) disable iff (!rstn_in)
		(ack_slot && data_r) |=> (addr_r[OFS_W-1:0] == sew_inc_ofs($past(addr_r[OFS_W-1:0])))
		&& (addr_r[ADDR_W-1:OFS_W] == $past(addr_r[ADDR_W-1:OFS_W])))
		else $error("page offset did not step within the row");

	// Programming-domain checks
	sequence s_hold_busy;
		busy_r[*8];
	endsequence

	a_prog_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		prog_go |=> s_hold_busy)
		else $error("programming cycle dropped busy early");

	a_prog_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(busy_r) |-> ($past(pcnt_r) == PROG_LAST))
		else $error("programming cycle length is wrong");

	a_wp_blocks: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(stop_ev && wp_s_r && !busy_r) |=> !busy_r && !cp_vld_r)
		else $error("protected write started programming");

endmodule

/* File: sim/sew_ctrl_model.sv */
// Two-wire bus controller; it pulls the line low or releases it
module sew_ctrl_model (
	output logic scl_out,
	output logic pull_out,
	input wire logic sda_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Low phase length; a larger value models a slow controller
	int low_ns = 6;

	// Bus idle: clock parked high, line released
	initial begin
		scl_out = 1'h1;
		pull_out = 1'h0;
	end

	// One clock: data moves mid low phase, line taken at the rise
	task automatic bit_cycle(input logic d, output logic q);
		#(low_ns / 2) pull_out = ~d;
		#(low_ns - low_ns / 2) scl_out = 1'h1;
		q = sda_in;
		#6 scl_out = 1'h0;
	endtask

	// Start from idle after bus free time, or repeated start
	task automatic start();
		if (scl_out === 1'h0) begin
			#3 pull_out = 1'h0;
			#3 scl_out = 1'h1;
		end else begin
			#30;
		end
		#3 pull_out = 1'h1;
		#3 scl_out = 1'h0;
	endtask

	// Eight bits MSB first, then the ninth clock with d9
	task automatic xfer(input logic [7:0] tx, input logic d9, output logic [7:0] rx,
		output logic q9);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(tx[i], rx[i]);
		end
		bit_cycle(d9, q9);
	endtask

	// Stop: line low under low clock, clock up, then line released
	task automatic stop();
		#3 pull_out = 1'h1;
		#3 scl_out = 1'h1;
		#3 pull_out = 1'h0;
	endtask
endmodule

/* File: sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sew_pkg::*;

	localparam int PLEN = 64;
	logic clk_in = 1'h0;
	logic rstn_in = 1'h0;
	logic [2:0] straps = 3'h5;
	logic wp = 1'h0;
	logic scl, pull, sda, sda_out, sda_oe, busy, a, q;
	logic [7:0] rx;
	logic [7:0] exp_mem [0:4095];
	int failures = 0;
	int n_tests = 0;
	int hi_cnt = 0;

	always #5 clk_in = ~clk_in;

	// Open-drain line with pull-up
	assign sda = ~pull & (sda_oe ? sda_out : 1'h1);

	sew_port #(.PROG_LEN(PLEN)) u_sew_port (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe),
		.chip_select_straps_in(straps),
		.wp_in(wp),
		.busy_out(busy)
	);

	sew_ctrl_model u_sew_ctrl_model (
		.scl_out(scl),
		.pull_out(pull),
		.sda_in(sda)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Busy length counted apart from the bench flow
	always @(posedge clk_in) hi_cnt <= hi_cnt + (busy === 1'h1);

	// Device may only pull low when it takes the line
	always @(posedge scl) if (sda_oe === 1'h1) check(16'(sda_out), 16'h0);

	task automatic dev(input logic [3:0] typ, input logic [2:0] sel, input logic rw,
		output logic ak);
		u_sew_ctrl_model.start();
		u_sew_ctrl_model.xfer({typ, sel, rw}, 1'h1, rx, q);
		ak = ~q;
	endtask

	// High byte upper nibble is don't-care, sent non-zero on purpose
	task automatic put_addr(input logic [11:0] addr);
		u_sew_ctrl_model.xfer({4'ha, addr[11:8]}, 1'h1, rx, q);
		check(16'(q), 16'h0);
		u_sew_ctrl_model.xfer(addr[7:0], 1'h1, rx, q);
		check(16'(q), 16'h0);
	endtask

	task automatic wr(input logic [11:0] addr, input int n, input logic [7:0] base);
		logic [11:0] p;
		dev(DEV_TYPE, straps, 1'h0, a);
		check(16'(a), 16'h1);
		put_addr(addr);
		for (int i = 0; i < n; i++) begin
			p = {addr[11:5], 5'(addr[4:0] + 5'(i))};
			u_sew_ctrl_model.xfer(base + 8'(i), 1'h1, rx, q);
			check(16'(q), 16'h0);
			if (wp === 1'h0) exp_mem[p] = base + 8'(i);
		end
		u_sew_ctrl_model.stop();
	endtask

	// Random read: dummy write, then repeated start drops it
	task automatic rd(input logic [11:0] addr, input int n);
		dev(DEV_TYPE, straps, 1'h0, a);
		put_addr(addr);
		dev(DEV_TYPE, straps, 1'h1, a);
		check(16'(a), 16'h1);
		for (int i = 0; i < n; i++) begin
			u_sew_ctrl_model.xfer(8'hff, i == n - 1, rx, q);
			check(16'(rx), 16'(exp_mem[12'(addr + 12'(i))]));
		end
		u_sew_ctrl_model.stop();
	endtask

	// Programming launch, refusal while busy, length, then ack polling
	task automatic prog(input logic want);
		int c;
		int s;
		s = hi_cnt;
		for (c = 0; c < 10 && busy !== 1'h1; c++) @(negedge clk_in);
		check(16'(busy), 16'(want));
		if (want) begin
			dev(DEV_TYPE, straps, 1'h0, a);
			u_sew_ctrl_model.stop();
			check(16'(a), 16'h0);
			for (c = 0; c < 1000 && busy === 1'h1; c++) @(negedge clk_in);
			check(16'(hi_cnt - s), 16'(PLEN));
			for (c = 0; c < 4; c++) begin
				dev(DEV_TYPE, straps, 1'h0, a);
				u_sew_ctrl_model.stop();
				if (a === 1'h1) break;
			end
			check(16'(a), 16'h1);
		end
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#200_000;
		failures++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge clk_in);
		@(negedge clk_in);
		rstn_in = 1'h1;
		repeat (4) @(negedge clk_in);
		// Wrong straps one bit at a time, then wrong type; later bytes ignored
		for (int i = 0; i < 4; i++) begin
			dev(i == 3 ? 4'hb : DEV_TYPE, straps ^ 3'(1 << i), 1'h0, a);
			check(16'(a), 16'h0);
			u_sew_ctrl_model.xfer(8'h00, 1'h1, rx, q);
			check(16'(q), 16'h1);
			u_sew_ctrl_model.stop();
		end
		prog(1'h0);
		wr(12'h000, 1, 8'h5a);
		prog(1'h1);
		// Slow page write of 34 bytes wraps inside its row
		u_sew_ctrl_model.low_ns = 20;
		wr(12'hfe5, 34, 8'h40);
		u_sew_ctrl_model.low_ns = 6;
		prog(1'h1);
		rd(12'hfe0, 33);
		prog(1'h0);
		// Protected write acked but not stored; reads unchanged
		@(negedge clk_in);
		wp = 1'h1;
		wr(12'h000, 1, 8'ha5);
		prog(1'h0);
		rd(12'h000, 1);
		@(negedge clk_in);
		wp = 1'h0;
		straps = 3'h2;
		// Read broken off mid-byte, then start, eighteen ones, start
		dev(DEV_TYPE, straps, 1'h1, a);
		check(16'(a), 16'h1);
		repeat (3) u_sew_ctrl_model.bit_cycle(1'h1, q);
		u_sew_ctrl_model.start();
		repeat (18) u_sew_ctrl_model.bit_cycle(1'h1, q);
		rd(12'hfe5, 2);
		final_report();
	end
endmodule
